// >>> dmac_top.sv
// dual multiply accumulate slice: accumulate mode and cascaded sum of products
//
// Behaviour
// - accumulate mode: each enabled valid cycle adds both products to the held accumulator, or to zero with acc_clear
// - accumulate mode: input and pipeline stages optional, output register always used
// - a separate accumulator adder adds the slice 0 sum to the held value, its result shown at the output
// - accumulate mode gives an overflow flag taken from a register
// - sum-of-products: first slice adds or subtracts its two products
// - sum-of-products: second slice does likewise with its own subtract select
// - sum-of-products: cascade adder sums both slice results into the output
// - sum-of-products: input, pipeline and output stages each enabled or bypassed
`include "dmac_map.svh"

module dmac_top
(
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire dmac_pkg::dmac_mode_t mode,
  input  wire logic                 ce,
  input  wire logic                 in_valid,
  input  wire logic                 acc_clear,
  input  wire logic                 in_reg_en,
  input  wire logic                 pipe_reg_en,
  input  wire logic                 out_reg_en,
  input  wire logic                 subtract_slice0,
  input  wire logic                 subtract_slice1,
  input  wire dmac_pkg::dmac_ops_t  ops_slice0,
  input  wire dmac_pkg::dmac_ops_t  ops_slice1,
  output dmac_pkg::dmac_acc_t       result,
  output logic                      result_valid,
  output logic                      overflow
);

  dmac_pkg::dmac_slice_cfg_t cfg_slice0;
  dmac_pkg::dmac_slice_cfg_t cfg_slice1;
  dmac_pkg::dmac_sum_t       sum_slice0;
  dmac_pkg::dmac_sum_t       sum_slice1;
  logic                      valid_slice0;
  logic                      valid_slice1;
  logic                      acc_mode;
  logic                      acc_step;
  logic                      casc_valid;
  dmac_pkg::dmac_acc_t       casc_sum;
  dmac_pkg::dmac_acc_t       result_q;
  logic                      valid_q;
  logic                      overflow_q;
  logic [`DMAC_ACCW:0]       wide_sum;
  dmac_pkg::dmac_acc_t       next_acc;
  logic                      next_overflow;
  dmac_pkg::dmac_acc_t       acc_base;

  // sign extension of a slice sum to accumulator width
  function automatic dmac_pkg::dmac_acc_t sext_sum(input dmac_pkg::dmac_sum_t s);
    sext_sum = {{(`DMAC_ACCW-`DMAC_SUMW){s[`DMAC_SUMW-1]}}, s};
  endfunction : sext_sum

  // output register in use: always in accumulate mode, by choice in cascade mode
  function automatic logic out_stage_used(input logic acc, input logic reg_en);
    out_stage_used = acc | reg_en;
  endfunction : out_stage_used

  assign acc_mode = (mode == dmac_pkg::dmac_dual_product_accumulate_mode);

  // accumulate mode always adds, so the subtract select of slice 0 is forced off
  always_comb
  begin
    cfg_slice0.in_reg_en   = in_reg_en;
    cfg_slice0.pipe_reg_en = pipe_reg_en;
    cfg_slice0.subtract    = acc_mode ? 1'h0 : subtract_slice0;
    cfg_slice1.in_reg_en   = in_reg_en;
    cfg_slice1.pipe_reg_en = pipe_reg_en;
    cfg_slice1.subtract    = subtract_slice1;
  end

  dmac_slice u_slice0
  (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .in_valid  (in_valid),
    .ops       (ops_slice0),
    .cfg       (cfg_slice0),
    .sum_out   (sum_slice0),
    .sum_valid (valid_slice0)
  );

  dmac_slice u_slice1
  (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .in_valid  (in_valid),
    .ops       (ops_slice1),
    .cfg       (cfg_slice1),
    .sum_out   (sum_slice1),
    .sum_valid (valid_slice1)
  );

  // accumulator datapath
  assign acc_step = ce & valid_slice0;
  assign acc_base = acc_clear ? `DMAC_ACC_RST : result_q;

  always_comb
  begin
    wide_sum      = {acc_base[`DMAC_ACCW-1], acc_base}
                    + {sum_slice0[`DMAC_SUMW-1], sext_sum(sum_slice0)};
    next_acc      = wide_sum[`DMAC_ACCW-1:0];
    next_overflow = wide_sum[`DMAC_ACCW] ^ wide_sum[`DMAC_ACCW-1];
  end

  // cascade adder
  assign casc_sum   = sext_sum(sum_slice0) + sext_sum(sum_slice1);
  assign casc_valid = valid_slice0 & valid_slice1;

  // output register, shared by accumulator and cascade output stage
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      result_q <= `DMAC_ACC_RST;
    end
    else if (acc_mode)
    begin
      if (acc_step)
      begin
        result_q <= next_acc;
      end
      else if (acc_clear)
      begin
        result_q <= `DMAC_ACC_RST;
      end
    end
    else if (ce)
    begin
      result_q <= casc_sum;
    end
  end

  // result valid tracking
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      valid_q <= `DMAC_BIT_RST;
    end
    else if (acc_mode)
    begin
      valid_q <= acc_step;
    end
    else if (ce)
    begin
      valid_q <= casc_valid;
    end
  end

  // overflow flag, refreshed on each accumulate step
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      overflow_q <= `DMAC_BIT_RST;
    end
    else if (!acc_mode)
    begin
      overflow_q <= `DMAC_BIT_RST;
    end
    else if (acc_step)
    begin
      overflow_q <= next_overflow;
    end
    else if (acc_clear)
    begin
      overflow_q <= `DMAC_BIT_RST;
    end
  end

  // accumulate mode ignores out_reg_en: output register always in use
  assign result       = out_stage_used(acc_mode, out_reg_en) ? result_q : casc_sum;
  assign result_valid = out_stage_used(acc_mode, out_reg_en) ? valid_q : casc_valid;
  assign overflow     = overflow_q;

endmodule : dmac_top

// >>> dmac_map.svh
// widths, reset values and encodings of the dual multiply accumulate slice
`ifndef DMAC_MAP_SVH
`define DMAC_MAP_SVH

// operand, product, slice sum and accumulator widths
`define DMAC_OPW        18
`define DMAC_PRODW      36
`define DMAC_SUMW       37
`define DMAC_ACCW       52

// reset values
`define DMAC_ACC_RST    52'h0_0000_0000_0000
`define DMAC_SUM_RST    37'h0_0000_0000
`define DMAC_PROD_RST   36'h0_0000_0000
`define DMAC_OP_RST     18'h0_0000
`define DMAC_BIT_RST    1'h0

// mode encodings
`define DMAC_MODE_ACC   1'h0
`define DMAC_MODE_CASC  1'h1

`endif

// >>> dmac_pkg.sv
// types shared by the dual multiply accumulate slice
`include "dmac_map.svh"

package dmac_pkg;

  typedef logic signed [`DMAC_OPW-1:0]   dmac_op_t;
  typedef logic signed [`DMAC_PRODW-1:0] dmac_prod_t;
  typedef logic signed [`DMAC_SUMW-1:0]  dmac_sum_t;
  typedef logic signed [`DMAC_ACCW-1:0]  dmac_acc_t;

  // two operand pairs of one slice
  typedef struct packed {
    dmac_op_t first_pair_left_operand;
    dmac_op_t first_pair_right_operand;
    dmac_op_t second_pair_left_operand;
    dmac_op_t second_pair_right_operand;
  } dmac_ops_t;

  // stage and subtract selection of one slice
  typedef struct packed {
    logic in_reg_en;
    logic pipe_reg_en;
    logic subtract;
  } dmac_slice_cfg_t;

  typedef enum logic [0:0] {
    dmac_dual_product_accumulate_mode = `DMAC_MODE_ACC,
    dmac_cascaded_sum_of_products_mode = `DMAC_MODE_CASC
  } dmac_mode_t;

endpackage : dmac_pkg

// >>> dmac_slice.sv
// one slice: two multipliers, optional input and pipeline stages, add or subtract
`include "dmac_map.svh"

module dmac_slice
(
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  input  wire logic                     ce,
  input  wire logic                     in_valid,
  input  wire dmac_pkg::dmac_ops_t      ops,
  input  wire dmac_pkg::dmac_slice_cfg_t cfg,
  output dmac_pkg::dmac_sum_t           sum_out,
  output logic                          sum_valid
);

  dmac_pkg::dmac_ops_t  ops_q;
  dmac_pkg::dmac_ops_t  ops_s;
  logic                 in_valid_q;
  logic                 valid_s;
  dmac_pkg::dmac_prod_t prod_first;
  dmac_pkg::dmac_prod_t prod_second;
  dmac_pkg::dmac_prod_t prod_first_q;
  dmac_pkg::dmac_prod_t prod_second_q;
  logic                 pipe_valid_q;
  dmac_pkg::dmac_prod_t prod_first_s;
  dmac_pkg::dmac_prod_t prod_second_s;
  dmac_pkg::dmac_sum_t  ext_first;
  dmac_pkg::dmac_sum_t  ext_second;

  // input stage
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ops_q      <= '0;
      in_valid_q <= `DMAC_BIT_RST;
    end
    else if (ce)
    begin
      ops_q      <= ops;
      in_valid_q <= in_valid;
    end
  end

  assign ops_s   = cfg.in_reg_en ? ops_q : ops;
  assign valid_s = cfg.in_reg_en ? in_valid_q : in_valid;

  // both products of the slice
  assign prod_first  = ops_s.first_pair_left_operand * ops_s.first_pair_right_operand;
  assign prod_second = ops_s.second_pair_left_operand * ops_s.second_pair_right_operand;

  // pipeline stage
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      prod_first_q  <= `DMAC_PROD_RST;
      prod_second_q <= `DMAC_PROD_RST;
      pipe_valid_q  <= `DMAC_BIT_RST;
    end
    else if (ce)
    begin
      prod_first_q  <= prod_first;
      prod_second_q <= prod_second;
      pipe_valid_q  <= valid_s;
    end
  end

  assign prod_first_s  = cfg.pipe_reg_en ? prod_first_q : prod_first;
  assign prod_second_s = cfg.pipe_reg_en ? prod_second_q : prod_second;
  assign sum_valid     = cfg.pipe_reg_en ? pipe_valid_q : valid_s;

  assign ext_first  = {prod_first_s[`DMAC_PRODW-1], prod_first_s};
  assign ext_second = {prod_second_s[`DMAC_PRODW-1], prod_second_s};

  // product sum never overflows one extra bit
  assign sum_out = cfg.subtract ? (ext_first - ext_second) : (ext_first + ext_second);

endmodule : dmac_slice

// >>> dmac_props.sv
// port checker of the dual multiply accumulate slice
module dmac_props
(
  input wire logic                 clk_sys,
  input wire logic                 sys_rst,
  input wire dmac_pkg::dmac_mode_t mode,
  input wire logic                 ce,
  input wire logic                 in_valid,
  input wire logic                 acc_clear,
  input wire logic                 in_reg_en,
  input wire logic                 pipe_reg_en,
  input wire logic                 out_reg_en,
  input wire logic                 subtract_slice0,
  input wire logic                 subtract_slice1,
  input wire dmac_pkg::dmac_ops_t  ops_slice0,
  input wire dmac_pkg::dmac_ops_t  ops_slice1,
  input wire dmac_pkg::dmac_acc_t  result,
  input wire logic                 result_valid,
  input wire logic                 overflow
);
  timeunit 1ns;
  timeprecision 1ps;
  dmac_pkg::dmac_acc_t s0;
  dmac_pkg::dmac_acc_t sc;
  logic                casc;
  logic                bp;
  logic                step;
  logic                rs;
  logic                ss;
  function automatic dmac_pkg::dmac_acc_t pair(dmac_pkg::dmac_ops_t o, logic sub);
    dmac_pkg::dmac_acc_t p;
    dmac_pkg::dmac_acc_t q;
    p = o.first_pair_left_operand * o.first_pair_right_operand;
    q = o.second_pair_left_operand * o.second_pair_right_operand;
    return sub ? p - q : p + q;
  endfunction : pair
  assign s0 = pair(ops_slice0, 1'h0);
  assign sc = pair(ops_slice0, subtract_slice0) + pair(ops_slice1, subtract_slice1);
  assign casc = mode == dmac_pkg::dmac_cascaded_sum_of_products_mode;
  assign bp = !in_reg_en && !pipe_reg_en;
  assign step = !casc && ce && in_valid && bp && !acc_clear;
  assign rs = result[51];
  assign ss = s0[51];
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  a_rst_clear: assert property (disable iff (1'h0) sys_rst && !casc ##1 !casc
    |-> result == '0 && !result_valid && !overflow) else $error("reset left state");
  a_acc_sum: assert property (step ##1 !casc
    |-> result == $past(result) + $past(s0) && result_valid) else $error("bad sum");
  a_ovf_flag: assert property (step ##1 !casc
    |-> overflow == ($past(rs) == $past(ss) && rs != $past(rs))) else $error("bad overflow");
  a_hold_idle: assert property (!casc && !ce ##1 !casc
    |-> $stable(result) && !result_valid) else $error("idle changed result");
  a_clear_acc: assert property (!casc && ce && acc_clear && !in_valid && bp ##1 !casc
    |-> result == '0 && !overflow) else $error("clear failed");
  a_casc_comb: assert property (casc && bp && !out_reg_en |-> result == sc)
    else $error("bad cascade sum");
  a_casc_reg: assert property ((casc && ce && in_reg_en && pipe_reg_en && out_reg_en
    && $stable(subtract_slice0) && $stable(subtract_slice1))[*3] ##1 casc && out_reg_en
    |-> result == $past(sc, 3)) else $error("bad cascade latency");
  a_casc_novf: assert property (casc ##1 casc |-> !overflow)
    else $error("overflow in cascade");
endmodule : dmac_props
bind dmac_top dmac_props u_props (.*);

// >>> dmac_fabric.sv
// fabric operand source: idle lines show the inverse of the last value
module dmac_fabric
(
  input  wire logic                clk_sys,
  input  wire logic                drive,
  input  wire dmac_pkg::dmac_ops_t want0,
  input  wire dmac_pkg::dmac_ops_t want1,
  output dmac_pkg::dmac_ops_t      ops0,
  output dmac_pkg::dmac_ops_t      ops1
);
  timeunit 1ns;
  timeprecision 1ps;
  dmac_pkg::dmac_ops_t last0 = '0;
  dmac_pkg::dmac_ops_t last1 = '0;
  assign ops0 = drive ? want0 : ~last0;
  assign ops1 = drive ? want1 : ~last1;
  // remember only what was driven, so idle lines hold one inverted value
  always @(posedge clk_sys)
  begin
    if (drive)
    begin
      last0 <= want0;
      last1 <= want1;
    end
  end
endmodule : dmac_fabric

// >>> tb_dmac_top.sv
// self-checking bench of the dual multiply accumulate slice
module tb_dmac_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    dmac_pkg::dmac_ops_t o0;
    dmac_pkg::dmac_ops_t o1;
    logic                s0;
    logic                s1;
    dmac_pkg::dmac_acc_t ex;
  } dmac_row_t;
  localparam dmac_pkg::dmac_mode_t casc_m = dmac_pkg::dmac_cascaded_sum_of_products_mode;
  logic                 clk_sys = 1'h0, sys_rst = 1'h1, ce = 1'h1, in_valid = 1'h0;
  logic                 acc_clear = 1'h0, in_reg_en = 1'h0, pipe_reg_en = 1'h0;
  logic                 out_reg_en = 1'h0, subtract_slice0 = 1'h0, subtract_slice1 = 1'h0;
  logic                 result_valid, overflow;
  dmac_pkg::dmac_mode_t mode = dmac_pkg::dmac_dual_product_accumulate_mode;
  dmac_pkg::dmac_ops_t  want0 = '0, want1 = '0, ops_slice0, ops_slice1;
  dmac_pkg::dmac_acc_t  result;
  dmac_row_t            rows [5];
  int                   errors = 0, compares = 0;
  dmac_top uut (.*);
  dmac_fabric partner (.clk_sys, .drive(in_valid), .want0, .want1, .ops0(ops_slice0),
                       .ops1(ops_slice1));
  always #12.5 clk_sys = ~clk_sys;
  function automatic dmac_pkg::dmac_ops_t mk(int a, int b, int c, int d);
    return {a[17:0], b[17:0], c[17:0], d[17:0]};
  endfunction : mk
  task automatic look(logic [1:0] f, dmac_pkg::dmac_acc_t r);
    compares++;
    if ({result_valid, overflow, result} !== {f, r})
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, {result_valid, overflow, result}, {f, r});
    end
  endtask : look
  task automatic stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial
  begin
    rows[0] = '{mk(3, 4, 5, 6), mk(-2, 7, 1, 1), 1'h0, 1'h0, 52'h1d};
    rows[1] = '{mk(3, 4, 5, 6), mk(-2, 7, 1, 1), 1'h1, 1'h0, -52'h1f};
    rows[2] = '{mk(3, 4, 5, 6), mk(-2, 7, 1, 1), 1'h0, 1'h1, 52'h1b};
    rows[3] = '{mk(3, 4, 5, 6), mk(-2, 7, 1, 1), 1'h1, 1'h1, -52'h21};
    rows[4] = '{mk(-131072, -131072, 131071, -131072), mk(0, 0, 0, 0), 1'h1, 1'h0,
                52'h0_0007_fffe_0000};
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'h0;
    @(negedge clk_sys);
    look(2'h0, '0);
    @(posedge clk_sys);
    mode <= casc_m;
    in_valid <= 1'h1;
    foreach (rows[i])
    begin
      @(posedge clk_sys);
      {want0, want1, subtract_slice0, subtract_slice1} <= {rows[i].o0, rows[i].o1, rows[i].s0, rows[i].s1};
      @(negedge clk_sys);
      look(2'h2, rows[i].ex);
    end
    @(posedge clk_sys);
    {in_reg_en, pipe_reg_en, out_reg_en} <= 3'h7;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    look(2'h2, rows[4].ex);
    @(posedge clk_sys);
    {want0, want1} <= {rows[1].o0, rows[1].o1};
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    look(2'h2, rows[4].ex);
    @(negedge clk_sys);
    look(2'h2, rows[1].ex);
    @(posedge clk_sys);
    mode <= dmac_pkg::dmac_dual_product_accumulate_mode;
    {in_reg_en, pipe_reg_en, acc_clear, in_valid} <= 4'h2;
    @(posedge clk_sys);
    {acc_clear, in_valid, want0} <= {2'h1, mk(3, 4, 5, 6)};
    @(negedge clk_sys);
    look(2'h0, '0);
    repeat (3) @(posedge clk_sys);
    ce <= 1'h0;
    @(negedge clk_sys);
    look(2'h2, 52'h7e);
    @(posedge clk_sys);
    {ce, acc_clear, want0} <= {2'h3, mk(-131072, -131072, -131072, -131072)};
    @(negedge clk_sys);
    look(2'h0, 52'h7e);
    @(posedge clk_sys);
    acc_clear <= 1'h0;
    repeat (65534) @(posedge clk_sys);
    @(negedge clk_sys);
    look(2'h2, 52'h7_fff8_0000_0000);
    @(posedge clk_sys);
    in_valid <= 1'h0;
    @(negedge clk_sys);
    look(2'h3, 52'h8_0000_0000_0000);
    @(posedge clk_sys);
    acc_clear <= 1'h1;
    @(posedge clk_sys);
    {acc_clear, in_reg_en, pipe_reg_en, in_valid, want0} <= {4'h7, mk(3, 4, 5, 6)};
    @(negedge clk_sys);
    look(2'h0, '0);
    @(posedge clk_sys);
    in_valid <= 1'h0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    look(2'h0, '0);
    @(negedge clk_sys);
    look(2'h2, 52'h2a);
    @(posedge clk_sys);
    in_valid <= 1'h1;
    @(posedge clk_sys);
    sys_rst <= 1'h1;
    in_valid <= 1'h0;
    @(posedge clk_sys);
    sys_rst <= 1'h0;
    repeat (3) @(negedge clk_sys);
    look(2'h0, '0);
    stop_test();
  end
  // whole run is about 65,600 cycles
  initial
  begin
    #1750000;
    errors++;
    stop_test();
  end
endmodule : tb_dmac_top
